//--- cfr_cfg.svh
// offsets, field positions, reset values and timing figures of the cell fault register slice
`ifndef CFR_CFG_SVH
`define CFR_CFG_SVH

// register offsets on the serial register link
`define CFR_ADDR_HIGH_FAULT 8'h22
`define CFR_ADDR_LOW_FAULT 8'h23
`define CFR_ADDR_PARITY_LOW 8'h24
`define CFR_ADDR_PARITY_HIGH 8'h25
`define CFR_ADDR_BEGIN_SAMPLE_SETUP 8'h30
`define CFR_ADDR_PIN_CTRL 8'h31
`define CFR_ADDR_BEGIN_SAMPLE_START 8'h34

// conversion setup field positions
`define CFR_SETUP_RSVD_BIT 7
`define CFR_SETUP_FORCE_ON_BIT 6
`define CFR_SETUP_THERM_MSB 5
`define CFR_SETUP_THERM_LSB 4
`define CFR_SETUP_ANALOG_BIT 3
`define CFR_SETUP_SPAN_MSB 2
`define CFR_SETUP_SPAN_LSB 0

// pin control field positions
`define CFR_PIN_AUX_BIT 7
`define CFR_PIN_DRIVE_BIT 6
`define CFR_PIN_LEVEL_BIT 5
`define CFR_PIN_SLEEP_BIT 2
`define CFR_PIN_RET_MSB 1
`define CFR_PIN_RET_LSB 0

// conversion start field position
`define CFR_START_BIT 0

// reset values and write masks
`define CFR_SETUP_RESET 8'h00
`define CFR_PIN_RESET 8'h00
`define CFR_SETUP_WMASK 8'h7f
`define CFR_PIN_WMASK 8'hc7

// span codes
`define CFR_SPAN_MAX_CODE 3'h5

// timing figures
`define CFR_MCLK_KHZ 20000
`define CFR_SLEEP_SETTLE_US 1000
`define CFR_REF_SETTLE_US 10
`define CFR_SLEEP_SETTLE_CYC ((`CFR_SLEEP_SETTLE_US * `CFR_MCLK_KHZ + 999) / 1000)
`define CFR_REF_SETTLE_CYC ((`CFR_REF_SETTLE_US * `CFR_MCLK_KHZ + 999) / 1000)

`endif

//--- cfr_pkg.sv
// types shared by the cell fault register slice
package cfr_pkg;

    // conversion setup register layout
    typedef struct packed {
        logic rsvd;
        logic force_on;
        logic [1:0] thermal_input_select;
        logic general_analog_input;
        logic [2:0] cell_span;
    } cfr_setup_t;

    // pin control register layout
    typedef struct packed {
        logic aux_switch;
        logic drive_open;
        logic pin_level;
        logic [1:0] rsvd;
        logic sleep;
        logic [1:0] thermal_return;
    } cfr_pin_ctrl_t;

    // setup handed to the converter at sequence start
    typedef struct packed {
        logic [1:0] thermal_input_select;
        logic general_analog_input;
        logic [5:0] cell_mask;
    } cfr_seq_t;

    // converter power sequencing
    typedef enum logic [2:0] {
        CFR_IDLE = 3'b001,
        CFR_SETTLE = 3'b010,
        CFR_RUN = 3'b100
    } cfr_begin_sample_state_t;

endpackage

//--- cfr_delay_timer.sv
// down-counter that runs for a fixed number of cycles after a start pulse
`timescale 1ns/100ps
module cfr_delay_timer #(
    parameter int CYCLES = 200
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // control
    input wire logic start,
    output logic busy
);
    localparam int CW = $clog2(CYCLES + 1);

    // refuse a delay the counter cannot express
    if (CYCLES < 1) begin : g_bad_cycles
        $error("cfr_delay_timer: CYCLES must be at least 1");
    end

    logic [CW-1:0] count_r;

    // load on start, otherwise count down to zero
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            count_r <= '0;
        end else if (start) begin
            count_r <= CW'(CYCLES);
        end else if (count_r != '0) begin
            count_r <= count_r - CW'(1);
        end
    end

    assign busy = (count_r != '0);
endmodule

//--- cfr_fault_capture.sv
// per-cell sticky fault flags behind one summary flag
`timescale 1ns/100ps
module cfr_fault_capture #(
    parameter int CELLS = 6
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // comparator side
    input wire logic compare_en,
    input wire logic [CELLS-1:0] fault_raw,
    // summary flag cleared by the host
    input wire logic clear,
    output logic [CELLS-1:0] flags
);
    // refuse a cell count the register cannot hold
    if (CELLS < 1 || CELLS > 8) begin : g_bad_cells
        $error("cfr_fault_capture: CELLS must be 1 to 8");
    end

    // one flag per cell; a fault in the clear cycle wins over the clear
    for (genvar i = 0; i < CELLS; i++) begin : g_cell
        always_ff @(posedge mclk) begin
            if (!reset_n) begin
                flags[i] <= 1'b0;
            end else if (compare_en && fault_raw[i]) begin
                flags[i] <= 1'b1;
            end else if (clear) begin
                flags[i] <= 1'b0;
            end
        end
    end
endmodule

//--- cfr_regs.sv
// cell fault flags, parity results, converter setup and pin control registers
`timescale 1ns/100ps
`include "cfr_cfg.svh"
module cfr_regs #(
    parameter int CELLS = 6,
    parameter int SLEEP_SETTLE_CYCLES = `CFR_SLEEP_SETTLE_CYC,
    parameter int REF_SETTLE_CYCLES = `CFR_REF_SETTLE_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // register access from the serial link decoder
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd_en,
    output logic [7:0] reg_rdata,
    // cell comparators and summary flag clears
    input wire logic [CELLS-1:0] cell_over,
    input wire logic [CELLS-1:0] cell_under,
    input wire logic high_flag_clear,
    input wire logic low_flag_clear,
    output logic compare_en,
    // parity check results of the protected bank
    input wire logic [7:0] parity_low_bits,
    input wire logic [3:0] parity_user_bits,
    // converter control
    input wire logic begin_sample_pin_start,
    input wire logic seq_done,
    output logic begin_sample_power,
    output logic seq_start,
    output logic begin_sample_busy,
    output cfr_pkg::cfr_seq_t seq_setup,
    // external pins and pin control outputs
    input wire logic gpio_in,
    output logic gpio_out,
    output logic gpio_oe,
    output logic aux_switch,
    output logic sleep_mode,
    output logic [1:0] thermal_return
);
    // refuse any cell count other than the six cells of the span codes
    if (CELLS != 6) begin : g_bad_cells
        $error("cfr_regs: CELLS must be 6 to match the span codes");
    end

    // span code to cell mask; codes beyond the top span fall back to cell one
    function automatic logic [5:0] span_mask(input logic [2:0] code);
        logic [5:0] m;
        m = 6'h01;
        if (code <= `CFR_SPAN_MAX_CODE) begin
            for (int k = 0; k < 6; k++) begin
                if (k <= int'(code)) begin
                    m[k] = 1'b1;
                end
            end
        end else begin
            m = 6'h01;
        end
        return m;
    endfunction

    cfr_pkg::cfr_setup_t setup_r;
    cfr_pkg::cfr_pin_ctrl_t pin_r;
    cfr_pkg::cfr_seq_t seq_setup_r;
    cfr_pkg::cfr_begin_sample_state_t state_r;
    cfr_pkg::cfr_begin_sample_state_t state_nxt;
    logic start_pend_r;
    logic start_pend_nxt;
    logic start_req;
    logic accept;
    logic sleep_exit;
    logic sleep_settling;
    logic ref_settling;
    logic ref_go;
    logic [CELLS-1:0] high_flags;
    logic [CELLS-1:0] low_flags;
    logic wr_setup;
    logic wr_pin;
    logic wr_start;

    // write decodes
    assign wr_setup = reg_wr_en && (reg_addr == `CFR_ADDR_BEGIN_SAMPLE_SETUP);
    assign wr_pin = reg_wr_en && (reg_addr == `CFR_ADDR_PIN_CTRL);
    assign wr_start = reg_wr_en && (reg_addr == `CFR_ADDR_BEGIN_SAMPLE_START);

    // conversion setup register; the top bit is kept at zero whatever is written
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            setup_r <= cfr_pkg::cfr_setup_t'(`CFR_SETUP_RESET);
        end else if (wr_setup) begin
            setup_r <= cfr_pkg::cfr_setup_t'(reg_wdata & `CFR_SETUP_WMASK);
        end
    end

    // pin control register; level and reserved bits are not stored
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            pin_r <= cfr_pkg::cfr_pin_ctrl_t'(`CFR_PIN_RESET);
        end else if (wr_pin) begin
            pin_r <= cfr_pkg::cfr_pin_ctrl_t'(reg_wdata & `CFR_PIN_WMASK);
        end
    end

    // pin outputs; a drive bit of one releases the open-drain pin for input use
    assign aux_switch = pin_r.aux_switch;
    assign gpio_out = 1'b0;
    assign gpio_oe = !pin_r.drive_open;
    assign thermal_return = pin_r.thermal_return;
    assign sleep_mode = pin_r.sleep;

    // sleep exit starts the sleep settle delay
    assign sleep_exit = wr_pin && pin_r.sleep && !reg_wdata[`CFR_PIN_SLEEP_BIT];

    cfr_delay_timer #(
        .CYCLES(SLEEP_SETTLE_CYCLES)
    ) u_sleep_settle (
        .mclk(mclk),
        .reset_n(reset_n),
        .start(sleep_exit),
        .busy(sleep_settling)
    );

    // comparators run only awake and settled
    assign compare_en = !pin_r.sleep && !sleep_settling;

    // per-cell overvoltage flags
    cfr_fault_capture #(
        .CELLS(CELLS)
    ) u_high_faults (
        .mclk(mclk),
        .reset_n(reset_n),
        .compare_en(compare_en),
        .fault_raw(cell_over),
        .clear(high_flag_clear),
        .flags(high_flags)
    );

    // per-cell undervoltage flags
    cfr_fault_capture #(
        .CELLS(CELLS)
    ) u_low_faults (
        .mclk(mclk),
        .reset_n(reset_n),
        .compare_en(compare_en),
        .fault_raw(cell_under),
        .clear(low_flag_clear),
        .flags(low_flags)
    );

    // start requests from the start bit or the start pin
    assign start_req = (wr_start && reg_wdata[`CFR_START_BIT]) || begin_sample_pin_start;
    assign accept = start_pend_r && (state_r == cfr_pkg::CFR_IDLE);

    // pending start; a new request in the accept cycle is kept
    always_comb begin
        start_pend_nxt = start_pend_r;
        if (accept) begin
            start_pend_nxt = 1'b0;
        end
        if (start_req) begin
            start_pend_nxt = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            start_pend_r <= 1'b0;
        end else begin
            start_pend_r <= start_pend_nxt;
        end
    end

    // reference settle delay runs only when auto mode powers up
    assign ref_go = accept && !setup_r.force_on;

    cfr_delay_timer #(
        .CYCLES(REF_SETTLE_CYCLES)
    ) u_ref_settle (
        .mclk(mclk),
        .reset_n(reset_n),
        .start(ref_go),
        .busy(ref_settling)
    );

    // converter sequencing
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            cfr_pkg::CFR_IDLE: begin
                if (accept) begin
                    if (setup_r.force_on) begin
                        state_nxt = cfr_pkg::CFR_RUN;
                    end else begin
                        state_nxt = cfr_pkg::CFR_SETTLE;
                    end
                end
            end
            cfr_pkg::CFR_SETTLE: begin
                if (!ref_settling) begin
                    state_nxt = cfr_pkg::CFR_RUN;
                end
            end
            cfr_pkg::CFR_RUN: begin
                if (seq_done) begin
                    state_nxt = cfr_pkg::CFR_IDLE;
                end
            end
            default: begin
                state_nxt = cfr_pkg::CFR_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state_r <= cfr_pkg::CFR_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // sequence start pulse toward the converter
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            seq_start <= 1'b0;
        end else begin
            seq_start <= (state_r != cfr_pkg::CFR_RUN) && (state_nxt == cfr_pkg::CFR_RUN);
        end
    end

    // setup captured at acceptance; later writes wait for the next sequence
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            seq_setup_r <= '0;
        end else if (accept) begin
            seq_setup_r.thermal_input_select <= setup_r.thermal_input_select;
            seq_setup_r.general_analog_input <= setup_r.general_analog_input;
            seq_setup_r.cell_mask <= span_mask(setup_r.cell_span);
        end
    end

    assign seq_setup = seq_setup_r;

    // converter power: forced on, or only while a sequence is under way
    assign begin_sample_power = setup_r.force_on || (state_r != cfr_pkg::CFR_IDLE);
    assign begin_sample_busy = (state_r != cfr_pkg::CFR_IDLE) || start_pend_r;

    // register read data, one cycle after the read strobe
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd_en) begin
            unique case (reg_addr)
                `CFR_ADDR_HIGH_FAULT: begin
                    reg_rdata <= {2'b00, high_flags};
                end
                `CFR_ADDR_LOW_FAULT: begin
                    reg_rdata <= {2'b00, low_flags};
                end
                `CFR_ADDR_PARITY_LOW: begin
                    reg_rdata <= parity_low_bits;
                end
                `CFR_ADDR_PARITY_HIGH: begin
                    reg_rdata <= {4'h0, parity_user_bits};
                end
                `CFR_ADDR_BEGIN_SAMPLE_SETUP: begin
                    reg_rdata <= setup_r;
                end
                `CFR_ADDR_PIN_CTRL: begin
                    reg_rdata <= {pin_r.aux_switch, pin_r.drive_open, gpio_in, 2'b00,
                                  pin_r.sleep, pin_r.thermal_return};
                end
                `CFR_ADDR_BEGIN_SAMPLE_START: begin
                    reg_rdata <= 8'h00;
                end
                default: begin
                    reg_rdata <= 8'h00;
                end
            endcase
        end
    end
endmodule

//--- cfr_regs_checker.sv
// port assertions for the cell fault register slice
`timescale 1ns/100ps
module cfr_regs_checker (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // register access
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_rdata,
    // sources and outputs watched
    input wire logic [7:0] parity_low_bits,
    input wire logic [3:0] parity_user_bits,
    input wire logic gpio_in,
    input wire logic compare_en,
    input wire logic sleep_mode,
    input wire logic seq_start,
    input wire logic begin_sample_power,
    input wire logic begin_sample_busy,
    input wire cfr_pkg::cfr_seq_t seq_setup
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    logic rd_ok;
    // a read with no write beside it
    assign rd_ok = reg_rd_en && !reg_wr_en;
    chk_high_reserved: assert property (rd_ok && reg_addr == 8'h22 |=> reg_rdata[7:6] == 2'b00)
        else $error("high fault reserved bits set");
    chk_low_reserved: assert property (rd_ok && reg_addr == 8'h23 |=> reg_rdata[7:6] == 2'b00)
        else $error("low fault reserved bits set");
    chk_parity_low: assert property (rd_ok && reg_addr == 8'h24
        |=> reg_rdata == $past(parity_low_bits))
        else $error("parity low read wrong");
    chk_parity_high: assert property (rd_ok && reg_addr == 8'h25
        |=> reg_rdata == {4'h0, $past(parity_user_bits)})
        else $error("parity high read wrong");
    chk_start_zero: assert property (rd_ok && reg_addr == 8'h34 |=> reg_rdata == 8'h00)
        else $error("start register not zero");
    chk_pin_level: assert property (rd_ok && reg_addr == 8'h31
        |=> reg_rdata[5] == $past(gpio_in) && reg_rdata[2] == sleep_mode)
        else $error("pin control read wrong");
    chk_sleep_off: assert property (sleep_mode |-> !compare_en)
        else $error("comparators on in sleep");
    chk_sleep_settle: assert property ($fell(sleep_mode) |-> !compare_en [*8])
        else $error("no settle after sleep");
    chk_start_power: assert property (seq_start |-> begin_sample_power && begin_sample_busy)
        else $error("sequence without power");
    chk_cell_span: assert property (seq_start |-> seq_setup.cell_mask[0]
        && (seq_setup.cell_mask & (seq_setup.cell_mask + 6'h01)) == 6'h00)
        else $error("cell span not from cell one");
    chk_start_pulse: assert property (seq_start |=> !seq_start)
        else $error("start pulse too long");
    // main scenarios reached
    cover property (seq_start);
    cover property ($fell(sleep_mode));
    cover property (rd_ok && reg_addr == 8'h22 ##1 reg_rdata != 8'h00);
endmodule

//--- cfr_begin_sample_model.sv
// converter model: a done pulse a set number of cycles after each start
`timescale 1ns/100ps
module cfr_begin_sample_model (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // sequence handshake
    input wire logic seq_start,
    input wire logic [7:0] done_delay,
    output logic seq_done
);
    logic [7:0] count_r;
    logic run_r;
    // count down from the start pulse, then pulse done once
    always_ff @(posedge mclk) begin
        seq_done <= 1'b0;
        if (!reset_n) begin
            run_r <= 1'b0;
            count_r <= 8'h00;
        end else if (seq_start) begin
            run_r <= 1'b1;
            count_r <= done_delay;
        end else if (run_r && count_r == 8'h00) begin
            run_r <= 1'b0;
            seq_done <= 1'b1;
        end else if (run_r) begin
            count_r <= count_r - 8'h01;
        end
    end
endmodule

//--- cfr_regs_test.sv
// self-checking bench for the cell fault register slice
`timescale 1ns/100ps
module cfr_regs_test;
    localparam int SLEEP_CYC = 16;
    localparam int REF_CYC = 4;
    logic mclk, reset_n, reg_wr_en, reg_rd_en, high_flag_clear, low_flag_clear;
    logic compare_en, begin_sample_pin_start, seq_done, begin_sample_power, seq_start, begin_sample_busy;
    logic gpio_in, gpio_out, gpio_oe, aux_switch, sleep_mode;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, parity_low_bits, done_delay, rd_data;
    logic [5:0] cell_over, cell_under;
    logic [3:0] parity_user_bits;
    logic [1:0] thermal_return;
    cfr_pkg::cfr_seq_t seq_setup;
    int failures, compares, cyc, starts, start_cyc, pin_cyc;
    cfr_regs #(.SLEEP_SETTLE_CYCLES(SLEEP_CYC), .REF_SETTLE_CYCLES(REF_CYC)) cfr_regs_inst (
        .mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
        .cell_over(cell_over), .cell_under(cell_under), .high_flag_clear(high_flag_clear),
        .low_flag_clear(low_flag_clear), .compare_en(compare_en),
        .parity_low_bits(parity_low_bits), .parity_user_bits(parity_user_bits),
        .begin_sample_pin_start(begin_sample_pin_start), .seq_done(seq_done), .begin_sample_power(begin_sample_power),
        .seq_start(seq_start), .begin_sample_busy(begin_sample_busy), .seq_setup(seq_setup),
        .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .aux_switch(aux_switch),
        .sleep_mode(sleep_mode), .thermal_return(thermal_return));
    cfr_begin_sample_model cfr_begin_sample_model_inst (.mclk(mclk), .reset_n(reset_n),
        .seq_start(seq_start), .done_delay(done_delay), .seq_done(seq_done));
    // clock
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // cycle stamps of pin starts and sequence starts
    always @(posedge mclk) begin
        cyc++;
        if (begin_sample_pin_start === 1'b1) pin_cyc = cyc;
        if (seq_start === 1'b1) begin
            starts++;
            start_cyc = cyc;
        end
    end
    task automatic wrap_up;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr_en <= 1'b1;
        @(posedge mclk);
        reg_wr_en <= 1'b0;
        #1;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd_en <= 1'b1;
        @(posedge mclk);
        reg_rd_en <= 1'b0;
        #1;
        chk({1'b0, reg_rdata}, {1'b0, exp});
    endtask
    // bounded wait: 0 idle, otherwise comparators back on
    task automatic wait_on(input int w, output int n);
        n = 0;
        while (((w == 0) ? begin_sample_busy !== 1'b0 : compare_en !== 1'b1) && n < 200) begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (n >= 200) begin
            failures++;
            $display("wrong value at %0t: wait ran out", $time);
            wrap_up;
        end
    endtask
    task automatic pin_start;
        @(posedge mclk);
        begin_sample_pin_start <= 1'b1;
        @(posedge mclk);
        begin_sample_pin_start <= 1'b0;
        #1;
    endtask
    task automatic t_reset;
        chk({3'h0, gpio_oe, aux_switch, sleep_mode, compare_en, begin_sample_power, begin_sample_busy}, 9'h024);
        rd_chk(8'h30, 8'h00);
        rd_chk(8'h31, 8'h20);
        $display("test reset done");
    endtask
    task automatic t_faults;
        @(posedge mclk);
        cell_over <= 6'h05;
        cell_under <= 6'h20;
        high_flag_clear <= 1'b1;
        @(posedge mclk);
        cell_over <= 6'h00;
        cell_under <= 6'h00;
        high_flag_clear <= 1'b0;
        rd_chk(8'h22, 8'h05);
        rd_chk(8'h23, 8'h20);
        @(posedge mclk);
        high_flag_clear <= 1'b1;
        @(posedge mclk);
        high_flag_clear <= 1'b0;
        low_flag_clear <= 1'b1;
        @(posedge mclk);
        low_flag_clear <= 1'b0;
        rd_chk(8'h22, 8'h00);
        rd_chk(8'h23, 8'h00);
        $display("test faults done");
    endtask
    task automatic t_regs;
        @(posedge mclk);
        parity_low_bits <= 8'ha5;
        parity_user_bits <= 4'hc;
        rd_chk(8'h24, 8'ha5);
        wr(8'h24, 8'h00);
        rd_chk(8'h24, 8'ha5);
        rd_chk(8'h25, 8'h0c);
        wr(8'h30, 8'h7f);
        rd_chk(8'h30, 8'h7f);
        wr(8'h34, 8'hfe);
        rd_chk(8'h34, 8'h00);
        rd_chk(8'h40, 8'h00);
        $display("test registers done");
    endtask
    task automatic t_span;
        logic [2:0] k;
        logic [5:0] m;
        int n;
        for (int c = 0; c < 8; c++) begin
            k = 3'(c);
            m = (k > 3'h5) ? 6'h01 : 6'h3f >> (3'h5 - k);
            wr(8'h30, {2'b01, k[1:0], k[0], k});
            wr(8'h34, 8'h01);
            wr(8'h30, 8'h40);
            wait_on(0, n);
            chk(seq_setup, {k[1:0], k[0], m});
        end
        $display("test span done");
    endtask
    task automatic t_power;
        int n;
        int s;
        wr(8'h30, 8'h05);
        chk({8'h00, begin_sample_power}, 9'h000);
        pin_start;
        wait_on(0, n);
        chk({8'h00, (start_cyc - pin_cyc) > REF_CYC}, 9'h001);
        chk({8'h00, begin_sample_power}, 9'h000);
        wr(8'h30, 8'h45);
        pin_start;
        wait_on(0, n);
        chk({8'h00, (start_cyc - pin_cyc) == 2}, 9'h001);
        chk({8'h00, begin_sample_power}, 9'h001);
        done_delay <= 8'h14;
        s = starts;
        wr(8'h34, 8'h01);
        wr(8'h34, 8'h01);
        wait_on(0, n);
        chk({8'h00, (starts - s) == 2}, 9'h001);
        $display("test power done");
    endtask
    task automatic t_sleep;
        int n;
        @(posedge mclk);
        gpio_in <= 1'b0;
        wr(8'h31, 8'hff);
        chk({3'h0, aux_switch, gpio_oe, sleep_mode, thermal_return, compare_en}, 9'h02e);
        rd_chk(8'h31, 8'hc7);
        @(posedge mclk);
        cell_over <= 6'h3f;
        @(posedge mclk);
        cell_over <= 6'h00;
        rd_chk(8'h22, 8'h00);
        wr(8'h31, 8'h40);
        wait_on(1, n);
        chk({8'h00, n >= SLEEP_CYC - 2}, 9'h001);
        chk({7'h00, gpio_oe, gpio_out}, 9'h000);
        $display("test sleep done");
    endtask
    // reset, then the scenarios
    initial begin
        {reset_n, reg_wr_en, reg_rd_en, high_flag_clear, low_flag_clear} = 5'h00;
        {begin_sample_pin_start, reg_addr, reg_wdata, cell_over, cell_under} = 29'h0;
        {parity_low_bits, parity_user_bits} = 12'h000;
        gpio_in = 1'b1;
        done_delay = 8'h03;
        repeat (16) @(posedge mclk);
        reset_n <= 1'b1;
        t_reset;
        t_faults;
        t_regs;
        t_span;
        t_power;
        t_sleep;
        wrap_up;
    end
endmodule
bind cfr_regs cfr_regs_checker cfr_regs_checker_inst (.mclk(mclk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
    .parity_low_bits(parity_low_bits), .parity_user_bits(parity_user_bits),
    .gpio_in(gpio_in), .compare_en(compare_en), .sleep_mode(sleep_mode),
    .seq_start(seq_start), .begin_sample_power(begin_sample_power), .begin_sample_busy(begin_sample_busy),
    .seq_setup(seq_setup));
